// ### psr_params.svh
// Constants of the port status and conversion result register bank
// Assumes AXI4-Lite byte addressing, one 32-bit word per register
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// ****************************************
// Address map
// ****************************************
`define PSR_ADDR_W          12
`define PSR_IDX_FUNC        4'h2
`define PSR_IDX_CTRL        4'h3
`define PSR_IDX_STATE       4'h5
`define PSR_IDX_DISC_LO     4'h6
`define PSR_IDX_DISC_HI     4'h7
`define PSR_IDX_VOLT_LO     4'h8
`define PSR_IDX_VOLT_HI     4'h9
`define PSR_ADDR_IRQ_STATUS 12'h100
`define PSR_ADDR_IRQ_MASK   12'h104

// ****************************************
// Fields and codes
// ****************************************
`define PSR_CTRL_START_BIT  3
`define PSR_WDOG_BIT        4
`define PSR_BUSY_BIT        3
`define PSR_DONE_BIT        7
`define PSR_FUNC_RESET      4'h0
`define PSR_FUNC_DISC1      4'h1
`define PSR_FUNC_DISC2      4'h2
`define PSR_FSTATE_RESET    3'h0
`define PSR_RESP_OKAY       2'h0
`define PSR_RESP_SLVERR     2'h2

`endif

// ### psr_pkg.sv
// Types shared by the port status and result bank
// Assumes nothing beyond a SystemVerilog compiler
package psr_pkg;

  typedef enum logic [0:0] {
    PSR_IDLE = 1'b0,
    PSR_BUSY = 1'b1
  } psr_conv_state_t;

  typedef enum logic [0:0] {
    PSR_KIND_VOLT = 1'b0,
    PSR_KIND_DISC = 1'b1
  } psr_kind_t;

  typedef logic [14:0] psr_result_t;

endpackage

// ### psr_port_meas.sv
// One port: function code, conversion launch and held 15-bit results
// Assumes the converter answers a launch with one conv_done pulse
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_port_meas
  import psr_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register writes
  input  wire logic        func_wr,
  input  wire logic [3:0]  func_data,
  input  wire logic        start_wr,
  // Converter
  input  wire logic        conv_done,
  input  wire psr_result_t conv_data,
  output var  logic        conv_start,
  output var  psr_kind_t   conv_kind,
  // Status
  output var  logic [3:0]  func_code,
  output var  logic        start_pend,
  output var  logic        busy,
  output var  psr_result_t disc_result,
  output var  logic        disc_done,
  output var  psr_result_t volt_result,
  output var  logic        volt_done,
  output var  logic        disc_evt,
  output var  logic        volt_evt
);

  psr_conv_state_t state_reg, state_next;
  psr_kind_t       kind_reg,  kind_next;
  psr_result_t     dres_reg,  dres_next;
  psr_result_t     vres_reg,  vres_next;
  logic [3:0]      func_reg,  func_next;
  logic            pend_reg,  pend_next;
  logic            start_reg, start_next;
  logic            dflag_reg, dflag_next;
  logic            vflag_reg, vflag_next;
  logic            devt_reg,  devt_next;
  logic            vevt_reg,  vevt_next;
  logic            disc_start;
  logic            is_disc_func;

  assign disc_start   = func_wr && (func_data == `PSR_FUNC_DISC1 || func_data == `PSR_FUNC_DISC2);
  assign is_disc_func = (func_reg == `PSR_FUNC_DISC1) || (func_reg == `PSR_FUNC_DISC2);

  always_comb begin
    state_next = state_reg;
    kind_next  = kind_reg;
    dres_next  = dres_reg;
    vres_next  = vres_reg;
    func_next  = func_reg;
    pend_next  = pend_reg;
    dflag_next = dflag_reg;
    vflag_next = vflag_reg;
    start_next = 1'b0;
    devt_next  = 1'b0;
    vevt_next  = 1'b0;
    unique case (state_reg)
      PSR_IDLE: begin
        if (pend_reg) begin
          state_next = PSR_BUSY;
          pend_next  = 1'b0;
          start_next = 1'b1;
          kind_next  = is_disc_func ? PSR_KIND_DISC : PSR_KIND_VOLT;
          if (!is_disc_func) begin
            vflag_next = 1'b0;
          end
        end
      end
      PSR_BUSY: begin
        if (conv_done) begin
          state_next = PSR_IDLE;
          if (kind_reg == PSR_KIND_DISC) begin
            dres_next  = conv_data;
            dflag_next = 1'b1;
            devt_next  = 1'b1;
          end else begin
            vres_next  = conv_data;
            vflag_next = 1'b1;
            vevt_next  = 1'b1;
          end
        end
      end
    endcase
    if (func_wr) begin
      func_next = func_data;
    end
    if (disc_start) begin
      pend_next  = 1'b1;
      dflag_next = 1'b0;
    end
    if (start_wr) begin
      pend_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= PSR_IDLE;
      kind_reg  <= PSR_KIND_VOLT;
      dres_reg  <= '0;
      vres_reg  <= '0;
      func_reg  <= `PSR_FUNC_RESET;
      pend_reg  <= 1'b0;
      start_reg <= 1'b0;
      dflag_reg <= 1'b0;
      vflag_reg <= 1'b0;
      devt_reg  <= 1'b0;
      vevt_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      dres_reg  <= dres_next;
      vres_reg  <= vres_next;
      func_reg  <= func_next;
      pend_reg  <= pend_next;
      start_reg <= start_next;
      dflag_reg <= dflag_next;
      vflag_reg <= vflag_next;
      devt_reg  <= devt_next;
      vevt_reg  <= vevt_next;
    end
  end

  assign conv_start  = start_reg;
  assign conv_kind   = kind_reg;
  assign func_code   = func_reg;
  assign start_pend  = pend_reg;
  assign busy        = (state_reg == PSR_BUSY);
  assign disc_result = dres_reg;
  assign disc_done   = dflag_reg;
  assign volt_result = vres_reg;
  assign volt_done   = vflag_reg;
  assign disc_evt    = devt_reg;
  assign volt_evt    = vevt_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence disc_finish_s;
    busy && kind_reg == PSR_KIND_DISC && conv_done && !disc_start;
  endsequence

  disc_flag_clear_a: assert property (disc_start |=> !disc_done)
    else $error("discovery flag not cleared at discovery start");
  disc_flag_set_a: assert property (disc_finish_s |=>
    disc_done && disc_result == $past(conv_data))
    else $error("discovery flag or result wrong after completion");
  volt_flag_clear_a: assert property (!busy && pend_reg && !is_disc_func |=>
    !volt_done ##1 1'b1)
    else $error("voltage flag not cleared at launch");
  start_launch_a: assert property (start_wr && !busy && !pend_reg |=>
    ##1 conv_start && busy && !start_pend)
    else $error("start bit did not launch one conversion");
  busy_end_a: assert property (busy && conv_done |=> !busy)
    else $error("busy flag stayed set after completion");
  volt_hold_a: assert property (!(busy && kind_reg == PSR_KIND_VOLT && conv_done) |=>
    $stable(volt_result))
    else $error("voltage result changed without completion");

endmodule

`default_nettype wire

// ### psr_irq_ctrl.sv
// Sticky event status, mask and one level interrupt
// Assumes event pulses are one cycle wide; write-one-to-clear
`timescale 1ns/1ps
`default_nettype none

module psr_irq_ctrl #(
  parameter int NUM_EVT = 8
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // Events and software access
  input  wire logic [NUM_EVT-1:0] evt,
  input  wire logic               clr_wr,
  input  wire logic               mask_wr,
  input  wire logic [NUM_EVT-1:0] wdata,
  // State
  output var  logic [NUM_EVT-1:0] status,
  output var  logic [NUM_EVT-1:0] mask,
  output var  logic               irq
);

  logic [NUM_EVT-1:0] status_reg, status_next;
  logic [NUM_EVT-1:0] mask_reg,   mask_next;
  logic               irq_reg,    irq_next;

  always_comb begin
    // Set wins over a clear in the same cycle so no event is lost
    status_next = (status_reg & ~(clr_wr ? wdata : '0)) | evt;
    mask_next   = mask_wr ? wdata : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg   <= '0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = irq_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  set_wins_a: assert property (clr_wr && |(evt & wdata) |=> |(status & $past(evt & wdata)))
    else $error("event lost against a clear");
  irq_level_a: assert property (##1 irq == |(status & mask))
    else $error("interrupt level does not match status and mask");

endmodule

`default_nettype wire

// ### psr_regs_top.sv
// Port status and conversion result registers behind an AXI4-Lite slave
// Assumes port state, watchdog and converter signals synchronous to core_clk
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_regs_top
  import psr_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // AXI4-Lite write address
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  input  wire logic [`PSR_ADDR_W-1:0]        s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  // AXI4-Lite write response
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  output var  logic [1:0]                    s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  input  wire logic [`PSR_ADDR_W-1:0]        s_axi_araddr,
  // AXI4-Lite read data
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output var  logic [31:0]                   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  // Port state inputs
  input  wire logic [NUM_PORTS-1:0]          port_wdog_active,
  input  wire logic [NUM_PORTS-1:0][2:0]     port_func_state,
  // Converter
  input  wire logic [NUM_PORTS-1:0]          conv_done,
  input  wire psr_result_t [NUM_PORTS-1:0]   conv_data,
  output var  logic [NUM_PORTS-1:0]          conv_start,
  output var  psr_kind_t [NUM_PORTS-1:0]     conv_kind,
  // Interrupt
  output var  logic                          irq
);

  localparam int         NUM_EVT = 2 * NUM_PORTS;
  localparam logic [2:0] NP      = 3'(NUM_PORTS);

  // Port select is two address bits wide, so more ports cannot be mapped
  initial begin
    if (NUM_PORTS < 1 || NUM_PORTS > 4) begin
      $error("NUM_PORTS must be 1 to 4");
    end
  end

  // ****************************************
  // Per-port state
  // ****************************************
  logic [NUM_PORTS-1:0]        func_wr;
  logic [NUM_PORTS-1:0]        start_wr;
  logic [NUM_PORTS-1:0][3:0]   func_code;
  logic [NUM_PORTS-1:0]        start_pend;
  logic [NUM_PORTS-1:0]        busy;
  psr_result_t [NUM_PORTS-1:0] disc_result;
  psr_result_t [NUM_PORTS-1:0] volt_result;
  logic [NUM_PORTS-1:0]        disc_done;
  logic [NUM_PORTS-1:0]        volt_done;
  logic [NUM_PORTS-1:0]        disc_evt;
  logic [NUM_PORTS-1:0]        volt_evt;
  logic [NUM_EVT-1:0]          evt;
  logic [NUM_EVT-1:0]          irq_status;
  logic [NUM_EVT-1:0]          irq_mask;

  // ****************************************
  // Write channel registers
  // ****************************************
  logic                   awready_reg, awready_next;
  logic                   wready_reg,  wready_next;
  logic                   aw_held_reg, aw_held_next;
  logic                   w_held_reg,  w_held_next;
  logic [`PSR_ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0]            w_data_reg,  w_data_next;
  logic [3:0]             w_strb_reg,  w_strb_next;
  logic                   bvalid_reg,  bvalid_next;
  logic [1:0]             bresp_reg,   bresp_next;
  logic                   wr_commit;
  logic                   wr_in_ports;
  logic                   wr_mapped;
  logic [1:0]             wr_port;
  logic [3:0]             wr_idx;
  logic                   irq_clr_wr;
  logic                   irq_mask_wr;

  assign wr_port     = aw_addr_reg[7:6];
  assign wr_idx      = aw_addr_reg[5:2];
  assign wr_commit   = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_in_ports = (aw_addr_reg[11:8] == 4'h0) && ({1'b0, wr_port} < NP);
  assign irq_clr_wr  = wr_commit && w_strb_reg[0] && aw_addr_reg == `PSR_ADDR_IRQ_STATUS;
  assign irq_mask_wr = wr_commit && w_strb_reg[0] && aw_addr_reg == `PSR_ADDR_IRQ_MASK;

  always_comb begin
    wr_mapped = (aw_addr_reg == `PSR_ADDR_IRQ_STATUS) || (aw_addr_reg == `PSR_ADDR_IRQ_MASK);
    if (wr_in_ports) begin
      wr_mapped = (wr_idx == `PSR_IDX_FUNC) || (wr_idx == `PSR_IDX_CTRL)
               || (wr_idx >= `PSR_IDX_STATE && wr_idx <= `PSR_IDX_VOLT_HI);
    end
  end

  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_commit) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_mapped ? `PSR_RESP_OKAY : `PSR_RESP_SLVERR;
    end
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    awready_next = !aw_held_next;
    wready_next  = !w_held_next;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PSR_RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ****************************************
  // Per-port blocks
  // ****************************************
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign func_wr[p]  = wr_commit && wr_in_ports && wr_port == 2'(p)
                      && wr_idx == `PSR_IDX_FUNC && w_strb_reg[0];
    assign start_wr[p] = wr_commit && wr_in_ports && wr_port == 2'(p)
                      && wr_idx == `PSR_IDX_CTRL && w_strb_reg[0]
                      && w_data_reg[`PSR_CTRL_START_BIT];
    assign evt[2*p]    = disc_evt[p];
    assign evt[2*p+1]  = volt_evt[p];

    psr_port_meas u_meas (
      .core_clk    (core_clk),
      .rst         (rst),
      .func_wr     (func_wr[p]),
      .func_data   (w_data_reg[3:0]),
      .start_wr    (start_wr[p]),
      .conv_done   (conv_done[p]),
      .conv_data   (conv_data[p]),
      .conv_start  (conv_start[p]),
      .conv_kind   (conv_kind[p]),
      .func_code   (func_code[p]),
      .start_pend  (start_pend[p]),
      .busy        (busy[p]),
      .disc_result (disc_result[p]),
      .disc_done   (disc_done[p]),
      .volt_result (volt_result[p]),
      .volt_done   (volt_done[p]),
      .disc_evt    (disc_evt[p]),
      .volt_evt    (volt_evt[p])
    );
  end

  psr_irq_ctrl #(
    .NUM_EVT (NUM_EVT)
  ) u_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .evt      (evt),
    .clr_wr   (irq_clr_wr),
    .mask_wr  (irq_mask_wr),
    .wdata    (w_data_reg[NUM_EVT-1:0]),
    .status   (irq_status),
    .mask     (irq_mask),
    .irq      (irq)
  );

  // ****************************************
  // Read channel
  // ****************************************
  logic        arready_reg, arready_next;
  logic        rvalid_reg,  rvalid_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [1:0]  rresp_reg,   rresp_next;
  logic [1:0]  rd_port;
  logic [3:0]  rd_idx;
  logic        rd_in_ports;
  logic        rd_take;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  logic        wdog_sel;
  logic [2:0]  fstate_sel;

  assign rd_port     = s_axi_araddr[7:6];
  assign rd_idx      = s_axi_araddr[5:2];
  assign rd_in_ports = (s_axi_araddr[11:8] == 4'h0) && ({1'b0, rd_port} < NP);
  assign rd_take     = s_axi_arvalid && arready_reg;
  assign wdog_sel    = port_wdog_active[rd_port];
  assign fstate_sel  = port_func_state[rd_port];

  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = rd_in_ports;
    unique case (rd_idx)
      `PSR_IDX_FUNC:    rd_byte = {4'h0, func_code[rd_port]};
      `PSR_IDX_CTRL:    rd_byte = 8'(start_pend[rd_port]) << `PSR_CTRL_START_BIT;
      `PSR_IDX_STATE:   rd_byte = {3'h0, wdog_sel, busy[rd_port], fstate_sel};
      `PSR_IDX_DISC_LO: rd_byte = disc_result[rd_port][7:0];
      `PSR_IDX_DISC_HI: rd_byte = {disc_done[rd_port], disc_result[rd_port][14:8]};
      `PSR_IDX_VOLT_LO: rd_byte = volt_result[rd_port][7:0];
      `PSR_IDX_VOLT_HI: rd_byte = {volt_done[rd_port], volt_result[rd_port][14:8]};
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_comb begin
    arready_next = arready_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_take) begin
      rvalid_next = 1'b1;
      rresp_next  = `PSR_RESP_OKAY;
      if (rd_hit) begin
        rdata_next = {24'h00_0000, rd_byte};
      end else if (s_axi_araddr == `PSR_ADDR_IRQ_STATUS) begin
        rdata_next = 32'(irq_status);
      end else if (s_axi_araddr == `PSR_ADDR_IRQ_MASK) begin
        rdata_next = 32'(irq_mask);
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = `PSR_RESP_SLVERR;
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `PSR_RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence state_read_s;
    rd_take && rd_in_ports && rd_idx == `PSR_IDX_STATE;
  endsequence

  state_unused_a: assert property (state_read_s |=> s_axi_rvalid && s_axi_rdata[7:5] == '0)
    else $error("status word unused bits not zero");
  state_fields_a: assert property (state_read_s |=>
    s_axi_rdata[`PSR_WDOG_BIT] == $past(wdog_sel) && s_axi_rdata[2:0] == $past(fstate_sel))
    else $error("status word fields wrong");
  write_resp_a: assert property (wr_commit |=> s_axi_bvalid && !aw_held_reg && !w_held_reg)
    else $error("write response not given one cycle after both parts");

endmodule

`default_nettype wire

// ### psr_regs_top_tb_top.sv
// Self-checking bench for the port status and result register bank
// Assumes the AXI4-Lite timing and address map of the design hand-over
`timescale 1ns/1ps
`default_nettype none
`include "psr_params.svh"

module psr_regs_top_tb_top
  import psr_pkg::*;
;
  logic core_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, wdog, cdone, cstart;
  logic [1:0] bresp, rresp, r;
  logic [3:0][2:0] fstate;
  psr_result_t [3:0] cdata;
  psr_kind_t [3:0] ckind;
  int fails, compares;

  psr_regs_top #(.NUM_PORTS(4)) u_psr_regs_top (
    .core_clk(core_clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .port_wdog_active(wdog), .port_func_state(fstate), .conv_done(cdone),
    .conv_data(cdata), .conv_start(cstart), .conv_kind(ckind), .irq(irq));

  // ****************************************
  // Bus cycles and checks
  // ****************************************
  function automatic logic [11:0] adr(input int p, input logic [3:0] i);
    adr = 12'(p * 64) + {6'h00, i, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Valid and payload stand until the edge that samples ready high
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic got;
    got = 0;
    // One edge between calls so no signal is driven twice in a step
    @(posedge core_clk);
    awvalid <= 1; awaddr <= a; wvalid <= 1; wdata <= v; wstrb <= 4'hf; bready <= 1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) begin
        got = 1;
        r = bresp;
      end
    end
    bready <= 0;
    chk(got, 1);
  endtask

  task automatic rd(input logic [11:0] a);
    logic got;
    got = 0;
    @(posedge core_clk);
    arvalid <= 1; araddr <= a; rready <= 1;
    for (int i = 0; i < 50 && !got; i++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 0;
      if (rvalid) begin
        got = 1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 0;
    chk(got, 1);
  endtask

  task automatic finish_conv(input int p, input logic [3:0] i, input psr_result_t v);
    @(posedge core_clk);
    cdone[p] <= 1; cdata[p] <= v;
    @(posedge core_clk);
    cdone[p] <= 0; cdata[p] <= ~v;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic wait_start(input int p, input psr_kind_t k);
    logic seen;
    seen = 0;
    for (int i = 0; i < 20 && !seen; i++) begin
      @(posedge core_clk);
      seen = cstart[p];
      if (seen) chk(ckind[p], k);
    end
    chk(seen, 1);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd(adr(0, `PSR_IDX_STATE)); chk(d, 0);
    rd(adr(0, `PSR_IDX_DISC_HI)); chk(d, 0);
  endtask

  task automatic t_status();
    for (int c = 0; c < 8; c++) begin
      fstate[2] <= 3'(c); wdog[2] <= c[0];
      rd(adr(2, `PSR_IDX_STATE)); chk(d, {27'h0, c[0], 1'b0, 3'(c)});
    end
  endtask

  task automatic t_disc(input logic [3:0] f, input psr_result_t v);
    wr(adr(1, `PSR_IDX_FUNC), {28'h0, f});
    wait_start(1, PSR_KIND_DISC);
    rd(adr(1, `PSR_IDX_DISC_HI)); chk(d[7], 0);
    rd(adr(1, `PSR_IDX_STATE)); chk(d[3], 1);
    finish_conv(1, `PSR_IDX_DISC_HI, v);
    rd(adr(1, `PSR_IDX_DISC_LO)); chk(d, {24'h0, v[7:0]});
    rd(adr(1, `PSR_IDX_DISC_HI)); chk(d, {24'h0, 1'b1, v[14:8]});
    rd(adr(1, `PSR_IDX_STATE)); chk(d[3], 0);
    // Event stays masked until the mask bit is written
    chk(irq, 0);
    wr(`PSR_ADDR_IRQ_MASK, 32'h0000_0004);
    #1 chk(irq, 1);
    wr(`PSR_ADDR_IRQ_STATUS, 32'h0000_0004);
    repeat (2) @(posedge core_clk);
    #1 chk(irq, 0);
    // Mask off again so the next call starts from a masked event
    wr(`PSR_ADDR_IRQ_MASK, 32'h0000_0000);
  endtask

  task automatic t_volt();
    wr(adr(1, `PSR_IDX_FUNC), 32'h0000_0003);
    wr(adr(1, `PSR_IDX_CTRL), 32'h0000_0008);
    wait_start(1, PSR_KIND_VOLT);
    rd(adr(1, `PSR_IDX_VOLT_HI)); chk(d[7], 0);
    finish_conv(1, `PSR_IDX_VOLT_HI, 15'h1234);
    rd(adr(1, `PSR_IDX_VOLT_LO)); chk(d, 32'h0000_0034);
    rd(adr(1, `PSR_IDX_VOLT_HI)); chk(d, 32'h0000_0092);
    rd(adr(1, `PSR_IDX_CTRL)); chk(d[3], 0);
  endtask

  task automatic t_bad();
    wr(adr(1, `PSR_IDX_DISC_LO), 32'h0000_00ff); chk(r, `PSR_RESP_OKAY);
    rd(adr(1, `PSR_IDX_DISC_LO)); chk(d, 32'h0000_0011);
    rd(12'h200); chk(r, `PSR_RESP_SLVERR);
    chk(d, 0);
  endtask

  task automatic give_verdict();
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // Clock, reset and sequence
  // ****************************************
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; wdog = 0; fstate = 0;
    cdone = 0; cdata = 0; fails = 0; compares = 0;
    repeat (6) @(posedge core_clk);
    rst <= 0;
    repeat (2) @(posedge core_clk);
    t_reset();
    t_status();
    t_disc(`PSR_FUNC_DISC1, 15'h5a3c);
    t_disc(`PSR_FUNC_DISC2, 15'h2a11);
    t_volt();
    t_bad();
    give_verdict();
  end

  // Whole run is under two hundred cycles; this span is far beyond it
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
